// file: inc/timer0_pkg.sv
package timer0_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 8;
  localparam int CNT_W = 8;
  localparam int PRESC_W = 10;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_COUNT = 8'h04;
  localparam logic [7:0] OFF_COMPARE = 8'h08;
  localparam logic [7:0] OFF_FLAGS = 8'h0C;
  localparam logic [7:0] OFF_MASK = 8'h10;
  localparam logic [7:0] OFF_ASYNC = 8'h14;

  // field positions
  localparam int CTRL_FORCE_BIT = 7;
  localparam int FLAG_OVF_BIT = 0;
  localparam int FLAG_CMP_BIT = 1;
  localparam int ASYNC_EN_BIT = 0;
  localparam int ASYNC_SEEN_BIT = 1;
  localparam int ASYNC_ACTIVE_BIT = 2;

  // reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] COUNT_RST = 8'h00;
  localparam logic [7:0] COMPARE_RST = 8'h00;
  localparam logic [1:0] FLAGS_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic ASYNC_EN_RST = 1'b0;

  localparam logic [7:0] CNT_BOTTOM = 8'h00;
  localparam logic [7:0] CNT_MAX = 8'hFF;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // compare output actions
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  // prescaler tap masks, one less than each division ratio
  localparam logic [9:0] DIV8_MASK = 10'h007;
  localparam logic [9:0] DIV32_MASK = 10'h01F;
  localparam logic [9:0] DIV64_MASK = 10'h03F;
  localparam logic [9:0] DIV128_MASK = 10'h07F;
  localparam logic [9:0] DIV256_MASK = 10'h0FF;
  localparam logic [9:0] DIV1024_MASK = 10'h3FF;

  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_PWM_PHASE,
    MODE_CTC,
    MODE_PWM_FAST
  } mode_t;

  typedef struct packed {
    logic force_cmp;
    logic [1:0] com;
    mode_t mode;
    logic [2:0] clock_select_bits;
  } ctrl_t;

endpackage

// file: rtl/osc_edge.sv
`timescale 1ns/1ps
module osc_edge (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic osc_pin_in,
  output logic rise,
  output logic level
);
  logic sync1_reg;
  logic sync2_reg;
  logic last_reg;

  // two-stage synchroniser; only sync2 is looked at
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      last_reg <= 1'b0;
    end else begin
      sync1_reg <= osc_pin_in;
      sync2_reg <= sync1_reg;
      last_reg <= sync2_reg;
    end
  end

  // crystal must run well below aclk/2 or edges are lost
  assign rise = sync2_reg & ~last_reg;
  assign level = sync2_reg;
endmodule

// file: rtl/prescaler10.sv
`timescale 1ns/1ps
module prescaler10
  import timer0_pkg::*;
#(
  parameter int WIDTH = PRESC_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic source_tick,
  input wire logic [2:0] clock_select_bits,
  output logic tick
);
  logic [WIDTH-1:0] div_reg;
  logic [9:0] mask;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_reg <= '0;
    end else if (source_tick) begin
      div_reg <= div_reg + 1'b1;
    end
  end

  always_comb begin
    case (clock_select_bits)
      3'h2: mask = DIV8_MASK;
      3'h3: mask = DIV32_MASK;
      3'h4: mask = DIV64_MASK;
      3'h5: mask = DIV128_MASK;
      3'h6: mask = DIV256_MASK;
      3'h7: mask = DIV1024_MASK;
      default: mask = 10'h000;
    endcase
  end

  // select code zero gives no tick at all
  assign tick = source_tick && (clock_select_bits != 3'h0) &&
                ((div_reg[9:0] & mask) == mask);
endmodule

// file: rtl/timer0_8bit_async_counter.sv
`timescale 1ns/1ps
// Functional notes
// - counter_value and compare_value are 8-bit registers reachable by the CPU.
// - every timer interrupt request is a bit in timer_irq_flags.
// - each source has a mask bit; a request is raised only when set.
// - timer clock comes from the prescaler or the external oscillator pin.
// - async_clock_status selects and reports asynchronous clocking.
// - counter holds still when no clock source is selected.
// - compare_value is compared with the counter on every timer tick.
// - comparator drives a waveform generator onto compare_out_pin.
// - a compare match sets compare_match_flag, which may request an interrupt.
// - bottom is signalled when the counter becomes zero.
// - max is signalled when the counter becomes 255.
// - top is either fixed max or compare_value, by mode.
// - clear-on-compare mode restarts counter from zero after the match.
// - phase-correct PWM mode, glitch-free through buffered compare value.
// - two sources, overflow and compare match, each with its own flag.
// - external watch crystal can clock the counter; prescaler is 10 bits.
// - select bits all zero stop the timer; CPU access to counter remains.
// - a CPU counter write beats any clear or count in that cycle.
// - compare flag sets one tick after match; cleared by ack or writing one.
module timer0_8bit_async_counter
  import timer0_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [timer0_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [timer0_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [timer0_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [timer0_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic osc_pin_in,
  output logic osc_pin_out,
  output logic compare_out_pin,
  output logic compare_out_en,
  output logic timer_irq,
  input wire logic irq_ack_ovf,
  input wire logic irq_ack_cmp
);
  import timer0_pkg::*;

  ctrl_t ctrl_reg;
  logic [CNT_W-1:0] counter_value_reg;
  logic [CNT_W-1:0] counter_value_next;
  logic [CNT_W-1:0] compare_buf_reg;
  logic [CNT_W-1:0] compare_value_reg;
  logic [1:0] timer_irq_flags_reg;
  logic [1:0] timer_irq_mask_reg;
  logic async_en_reg;
  logic async_seen_reg;
  logic dir_down_reg;
  logic dir_down_next;
  logic block_reg;
  logic oc_state_reg;
  logic oc_state_next;

  logic [ADDR_W-1:0] aw_addr_reg;
  logic [DATA_W-1:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic arready_reg;
  logic rvalid_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic out_pin_reg;
  logic out_en_reg;
  logic irq_reg;
  logic osc_out_reg;

  logic osc_rise;
  logic osc_level;
  logic source_tick;
  logic tick;
  logic wr_fire;
  logic wr_lane0;
  logic wr_ctrl;
  logic wr_count;
  logic wr_compare;
  logic wr_flags;
  logic wr_mask;
  logic wr_async;
  logic wr_mapped;
  logic at_bottom;
  logic at_max;
  logic match;
  logic cmp_event;
  logic ovf_event;
  logic pwm_mode;
  logic force_hit;
  logic [DATA_W-1:0] rd_word;
  logic rd_mapped;

  osc_edge u_osc (
    .aclk(aclk),
    .aresetn(aresetn),
    .osc_pin_in(osc_pin_in),
    .rise(osc_rise),
    .level(osc_level)
  );

  // asynchronous source counts rising crystal edges, otherwise every aclk
  assign source_tick = async_en_reg ? osc_rise : 1'b1;

  prescaler10 #(
    .WIDTH(PRESC_W)
  ) u_presc (
    .aclk(aclk),
    .aresetn(aresetn),
    .source_tick(source_tick),
    .clock_select_bits(ctrl_reg.clock_select_bits),
    .tick(tick)
  );

  // ---------------- AXI4-Lite write channel ----------------
  assign wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
  assign wr_lane0 = wr_fire && w_strb_reg[0];
  assign wr_ctrl = wr_lane0 && (aw_addr_reg == OFF_CTRL);
  assign wr_count = wr_lane0 && (aw_addr_reg == OFF_COUNT);
  assign wr_compare = wr_lane0 && (aw_addr_reg == OFF_COMPARE);
  assign wr_flags = wr_lane0 && (aw_addr_reg == OFF_FLAGS);
  assign wr_mask = wr_lane0 && (aw_addr_reg == OFF_MASK);
  assign wr_async = wr_lane0 && (aw_addr_reg == OFF_ASYNC);
  assign wr_mapped = (aw_addr_reg == OFF_CTRL) ||
                     (aw_addr_reg == OFF_COUNT) ||
                     (aw_addr_reg == OFF_COMPARE) ||
                     (aw_addr_reg == OFF_FLAGS) ||
                     (aw_addr_reg == OFF_MASK) ||
                     (aw_addr_reg == OFF_ASYNC);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
      aw_addr_reg <= '0;
      w_data_reg <= '0;
      w_strb_reg <= 4'h0;
    end else begin
      if (awready_reg && s_axi_awvalid) begin
        awready_reg <= 1'b0;
        aw_addr_reg <= {s_axi_awaddr[ADDR_W-1:2], 2'b00};
      end
      if (wready_reg && s_axi_wvalid) begin
        wready_reg <= 1'b0;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg <= 1'b1;
      end
    end
  end

  // ---------------- AXI4-Lite read channel ----------------
  always_comb begin
    rd_word = '0;
    rd_mapped = 1'b1;
    case ({s_axi_araddr[ADDR_W-1:2], 2'b00})
      OFF_CTRL: rd_word[7:0] = {1'b0, ctrl_reg[6:0]};
      OFF_COUNT: rd_word[7:0] = counter_value_reg;
      OFF_COMPARE: rd_word[7:0] = compare_buf_reg;
      OFF_FLAGS: rd_word[1:0] = timer_irq_flags_reg;
      OFF_MASK: rd_word[1:0] = timer_irq_mask_reg;
      OFF_ASYNC: begin
        rd_word[ASYNC_EN_BIT] = async_en_reg;
        rd_word[ASYNC_SEEN_BIT] = async_seen_reg;
        rd_word[ASYNC_ACTIVE_BIT] = async_en_reg && osc_level;
      end
      default: rd_mapped = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= '0;
      rresp_reg <= RESP_OKAY;
    end else begin
      if (arready_reg && s_axi_arvalid) begin
        arready_reg <= 1'b0;
        rvalid_reg <= 1'b1;
        rdata_reg <= rd_word;
        rresp_reg <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end
      if (rvalid_reg && s_axi_rready) begin
        rvalid_reg <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // ---------------- configuration ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg <= CTRL_RST;
      timer_irq_mask_reg <= MASK_RST;
    end else begin
      if (wr_ctrl) begin
        // force is a strobe and is never stored
        ctrl_reg <= {1'b0, w_data_reg[6:0]};
      end
      if (wr_mask) begin
        timer_irq_mask_reg <= w_data_reg[1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      async_en_reg <= ASYNC_EN_RST;
      async_seen_reg <= 1'b0;
    end else begin
      if (wr_async) begin
        async_en_reg <= w_data_reg[ASYNC_EN_BIT];
      end
      // sticky proof that the crystal runs; dropping async mode clears it
      if (wr_async && !w_data_reg[ASYNC_EN_BIT]) begin
        async_seen_reg <= 1'b0;
      end else if (async_en_reg && osc_rise) begin
        async_seen_reg <= 1'b1;
      end
    end
  end

  // ---------------- counter unit ----------------
  assign pwm_mode = (ctrl_reg.mode == MODE_PWM_PHASE) ||
                    (ctrl_reg.mode == MODE_PWM_FAST);
  assign at_bottom = (counter_value_reg == CNT_BOTTOM);
  assign at_max = (counter_value_reg == CNT_MAX);
  assign match = (counter_value_reg == compare_value_reg);

  always_comb begin
    counter_value_next = counter_value_reg + 1'b1;
    dir_down_next = 1'b0;
    ovf_event = 1'b0;
    case (ctrl_reg.mode)
      MODE_NORMAL: begin
        ovf_event = at_max;
      end
      MODE_CTC: begin
        // top is compare_value; wrap from max only if compare was passed
        // a blocked match after a counter write does not clear either
        if (match && !block_reg) begin
          counter_value_next = CNT_BOTTOM;
        end
        ovf_event = at_max && !(match && !block_reg);
      end
      MODE_PWM_PHASE: begin
        // counts up to max, turns, counts down to bottom
        dir_down_next = dir_down_reg;
        if (!dir_down_reg && at_max) begin
          dir_down_next = 1'b1;
        end else if (dir_down_reg && at_bottom) begin
          dir_down_next = 1'b0;
        end
        if (dir_down_next) begin
          counter_value_next = counter_value_reg - 1'b1;
        end
        ovf_event = dir_down_reg && at_bottom;
      end
      MODE_PWM_FAST: begin
        ovf_event = at_max;
      end
      default: begin
        counter_value_next = counter_value_reg;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_value_reg <= COUNT_RST;
      dir_down_reg <= 1'b0;
    end else if (wr_count) begin
      counter_value_reg <= w_data_reg[CNT_W-1:0];
    end else if (tick) begin
      counter_value_reg <= counter_value_next;
      dir_down_reg <= dir_down_next;
    end
  end

  // a counter write masks the match seen on the following tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      block_reg <= 1'b0;
    end else if (wr_count) begin
      block_reg <= 1'b1;
    end else if (tick) begin
      block_reg <= 1'b0;
    end
  end

  // ---------------- compare value, buffered in PWM modes ----------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_buf_reg <= COMPARE_RST;
      compare_value_reg <= COMPARE_RST;
    end else begin
      if (wr_compare) begin
        compare_buf_reg <= w_data_reg[CNT_W-1:0];
      end
      if (wr_compare && !pwm_mode) begin
        compare_value_reg <= w_data_reg[CNT_W-1:0];
      end else if (pwm_mode && tick && at_max) begin
        // update only at the turn point, so no odd-length pulse appears
        compare_value_reg <= compare_buf_reg;
      end
    end
  end

  // ---------------- flags ----------------
  // the match of the reached value is flagged on the following tick
  assign cmp_event = tick && match && !block_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_irq_flags_reg <= FLAGS_RST;
    end else begin
      // set beats a clear that lands in the same cycle
      if (tick && ovf_event) begin
        timer_irq_flags_reg[FLAG_OVF_BIT] <= 1'b1;
      end else if ((wr_flags && w_data_reg[FLAG_OVF_BIT]) || irq_ack_ovf) begin
        timer_irq_flags_reg[FLAG_OVF_BIT] <= 1'b0;
      end
      if (cmp_event) begin
        timer_irq_flags_reg[FLAG_CMP_BIT] <= 1'b1;
      end else if ((wr_flags && w_data_reg[FLAG_CMP_BIT]) || irq_ack_cmp) begin
        timer_irq_flags_reg[FLAG_CMP_BIT] <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(timer_irq_flags_reg & timer_irq_mask_reg);
    end
  end

  // ---------------- waveform generator ----------------
  assign force_hit = wr_ctrl && w_data_reg[CTRL_FORCE_BIT] && !pwm_mode;

  always_comb begin
    oc_state_next = oc_state_reg;
    case (ctrl_reg.mode)
      MODE_NORMAL, MODE_CTC: begin
        // toggle mode with ctc gives the frequency output
        if (cmp_event || force_hit) begin
          case (ctrl_reg.com)
            COM_TOGGLE: oc_state_next = !oc_state_reg;
            COM_CLEAR: oc_state_next = 1'b0;
            COM_SET: oc_state_next = 1'b1;
            default: oc_state_next = oc_state_reg;
          endcase
        end
      end
      MODE_PWM_PHASE: begin
        if (cmp_event && ctrl_reg.com[1]) begin
          oc_state_next = dir_down_reg ^ ctrl_reg.com[0];
        end
      end
      MODE_PWM_FAST: begin
        if (cmp_event && ctrl_reg.com[1]) begin
          oc_state_next = ctrl_reg.com[0];
        end else if (tick && at_max && ctrl_reg.com[1]) begin
          oc_state_next = !ctrl_reg.com[0];
        end
      end
      default: oc_state_next = oc_state_reg;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      oc_state_reg <= 1'b0;
      out_pin_reg <= 1'b0;
      out_en_reg <= 1'b0;
    end else begin
      oc_state_reg <= oc_state_next;
      out_pin_reg <= (ctrl_reg.com != COM_OFF) && oc_state_next;
      out_en_reg <= (ctrl_reg.com != COM_OFF);
    end
  end

  // inverting feedback for the crystal amplifier while async is on
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_out_reg <= 1'b0;
    end else begin
      osc_out_reg <= async_en_reg && !osc_level;
    end
  end

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign compare_out_pin = out_pin_reg;
  assign compare_out_en = out_en_reg;
  assign timer_irq = irq_reg;
  assign osc_pin_out = osc_out_reg;
endmodule

// file: testbench/timer0_chk.sv
`timescale 1ns/1ps
module timer0_chk
  import timer0_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [timer0_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic compare_out_pin,
  input wire logic compare_out_en
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  property p_wr_ans;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> !s_axi_awready && !s_axi_bvalid ##1 s_axi_bvalid;
  endproperty
  a_wr_ans: assert property (p_wr_ans)
    else $error("write answer late");
  property p_w_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_refuse: assert property (p_w_refuse)
    else $error("write taken while answering");
  property p_b_done;
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready;
  endproperty
  a_b_done: assert property (p_b_done)
    else $error("write answer not released");
  property p_rd_ans;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready;
  endproperty
  a_rd_ans: assert property (p_rd_ans)
    else $error("read answer late");
  property p_r_refuse;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_refuse: assert property (p_r_refuse)
    else $error("read taken while answering");
  property p_r_done;
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready;
  endproperty
  a_r_done: assert property (p_r_done)
    else $error("read answer repeated");
  property p_r_err;
    s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == '0;
  endproperty
  a_r_err: assert property (p_r_err)
    else $error("error read carries data");
  property p_pin_idle;
    !compare_out_en |-> !compare_out_pin;
  endproperty
  a_pin_idle: assert property (p_pin_idle)
    else $error("undriven pin not low");
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
  c_rd_err: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
  c_pin: cover property ($rose(compare_out_pin));
endmodule
bind timer0_8bit_async_counter timer0_chk chk_i (.*);

// file: testbench/cpu_model.sv
`timescale 1ns/1ps
module cpu_model
  import timer0_pkg::*;
(
  input wire logic aclk,
  output logic [timer0_pkg::ADDR_W-1:0] s_axi_awaddr,
  output logic [2:0] s_axi_awprot,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [timer0_pkg::DATA_W-1:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [timer0_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic [2:0] s_axi_arprot,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [timer0_pkg::DATA_W-1:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready,
  output logic irq_ack_ovf,
  output logic irq_ack_cmp
);
  initial begin
    {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arprot} = '0;
    {s_axi_arvalid, s_axi_rready, irq_ack_ovf, irq_ack_cmp} = '0;
    s_axi_wstrb = 4'hF;
  end
  // address and data offered together; each dropped once its ready is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    output logic [1:0] resp);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v,
                    output logic [1:0] resp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    v = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // interrupt entry acknowledges the serviced source for one cycle
  task automatic ack(input logic ovf, input logic cmp);
    @(posedge aclk);
    irq_ack_ovf <= ovf;
    irq_ack_cmp <= cmp;
    @(posedge aclk);
    irq_ack_ovf <= 1'b0;
    irq_ack_cmp <= 1'b0;
  endtask
endmodule

// file: testbench/tb.sv
`timescale 1ns/1ps
module tb;
  import timer0_pkg::*;
  localparam int LIMIT = 20000;
  logic aclk, aresetn, osc_pin_in, osc_pin_out, timer_irq;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, compare_out_pin, compare_out_en;
  logic irq_ack_ovf, irq_ack_cmp;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata, d;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;
  int p;
  cpu_model cpu (.*);
  timer0_8bit_async_counter dut (.*);
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // crystal stand-in runs free, slower than aclk/4 for the synchroniser
  initial begin
    osc_pin_in = 1'b0;
    // offset keeps crystal edges away from the aclk edges
    #20;
    forever #350 osc_pin_in = ~osc_pin_in;
  end
  always @(posedge aclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_total++;
      print_verdict();
    end
  end
  task automatic print_verdict;
    if (err_total == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s,
                     input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_total++;
      $display("mismatch %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [31:0] v);
    cpu.wr(a, v, r);
    chk("bresp", 32'(r), 32'(RESP_OKAY));
  endtask
  task automatic rreg(input logic [7:0] a, input logic [31:0] e);
    cpu.rd(a, d, r);
    chk($sformatf("reg_%0h", a), d, e);
    chk("rresp", 32'(r), 32'(RESP_OKAY));
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // cycles spanned by k pin changes, starting at the next change
  task automatic gap(input int k, output int g);
    logic v;
    g = 0;
    v = compare_out_pin;
    while (compare_out_pin === v) @(posedge aclk);
    repeat (k) begin
      v = compare_out_pin;
      while (compare_out_pin === v) begin
        @(posedge aclk);
        g++;
      end
    end
  endtask
  initial begin
    aresetn = 1'b0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 6; i++)
      rreg(8'(4 * i), 32'h0);
    cpu.rd(8'h18, d, r);
    chk("unmapped_rdata", d, 32'h0);
    chk("unmapped_rresp", 32'(r), 32'(RESP_SLVERR));
    cpu.wr(8'h18, 32'h5A, r);
    chk("unmapped_bresp", 32'(r), 32'(RESP_SLVERR));
    wreg(OFF_COUNT, 32'h37);
    cyc(20);
    rreg(OFF_COUNT, 32'h37);
    // compare still 0, so the wrap is followed by a match as well
    wreg(OFF_COUNT, 32'hF0);
    wreg(OFF_CTRL, 32'h01);
    cyc(30);
    wreg(OFF_CTRL, 32'h00);
    rreg(OFF_FLAGS, 32'h3);
    chk("irq_masked", 32'(timer_irq), 32'h0);
    wreg(OFF_MASK, 32'h1);
    cyc(3);
    chk("irq_ovf", 32'(timer_irq), 32'h1);
    wreg(OFF_FLAGS, 32'h1);
    cyc(3);
    chk("irq_cleared", 32'(timer_irq), 32'h0);
    rreg(OFF_FLAGS, 32'h2);
    wreg(OFF_MASK, 32'h2);
    cyc(3);
    chk("irq_cmp", 32'(timer_irq), 32'h1);
    cpu.ack(1'b0, 1'b1);
    cyc(3);
    chk("irq_acked", 32'(timer_irq), 32'h0);
    rreg(OFF_FLAGS, 32'h0);
    wreg(OFF_COMPARE, 32'h20);
    wreg(OFF_COUNT, 32'h20);
    wreg(OFF_CTRL, 32'h01);
    cyc(5);
    wreg(OFF_CTRL, 32'h00);
    rreg(OFF_FLAGS, 32'h0);
    wreg(OFF_COMPARE, 32'h09);
    wreg(OFF_COUNT, 32'h00);
    wreg(OFF_CTRL, 32'h31);
    gap(1, p);
    chk("ctc_gap", 32'(p), 32'd10);
    chk("pin_en", 32'(compare_out_en), 32'h1);
    wreg(OFF_CTRL, 32'h30);
    rreg(OFF_FLAGS, 32'h2);
    cpu.rd(OFF_COUNT, d, r);
    chk("ctc_top", 32'(d <= 32'h9), 32'h1);
    wreg(OFF_FLAGS, 32'h3);
    p = int'(compare_out_pin);
    wreg(OFF_CTRL, 32'hA0);
    cyc(3);
    chk("force_pin", 32'(compare_out_pin), 32'(p == 0));
    rreg(OFF_FLAGS, 32'h0);
    rreg(OFF_CTRL, 32'h20);
    wreg(OFF_COMPARE, 32'h40);
    wreg(OFF_CTRL, 32'h49);
    gap(2, p);
    chk("pwm_period", 32'(p), 32'd510);
    wreg(OFF_CTRL, 32'h00);
    wreg(OFF_COUNT, 32'h00);
    wreg(OFF_CTRL, 32'h07);
    cyc(3072);
    wreg(OFF_CTRL, 32'h00);
    cpu.rd(OFF_COUNT, d, r);
    chk("div1024", 32'(d inside {32'h3, 32'h4}), 32'h1);
    wreg(OFF_ASYNC, 32'h1);
    wreg(OFF_COUNT, 32'h00);
    wreg(OFF_CTRL, 32'h01);
    cyc(70);
    wreg(OFF_CTRL, 32'h00);
    cpu.rd(OFF_COUNT, d, r);
    chk("osc_count", 32'(d inside {[32'h9:32'hC]}), 32'h1);
    cpu.rd(OFF_ASYNC, d, r);
    chk("async_stat", d & 32'h3, 32'h3);
    @(posedge osc_pin_in);
    chk("osc_out_hi", 32'(osc_pin_out), 32'h1);
    cyc(4);
    chk("osc_out_lo", 32'(osc_pin_out), 32'h0);
    wreg(OFF_ASYNC, 32'h0);
    rreg(OFF_ASYNC, 32'h0);
    print_verdict();
  end
endmodule
